// file: rtl/pie_pkg.sv
// Package: register map, field positions and bus types of the enable block
// How it works
// - No peripheral request leaves while the group enable is clear.
// - Both enable registers are read/write and clear on any reset.
// - First register: bit 0 timer one overflow, bit 7 gate acquisition.
// - First register: bit 1 gates the timer two period match.
// - First register: bit 5 gates the serial receive interrupt.
// - First register: bit 4 gates the serial transmit interrupt.
// - First register: bit 6 converter, bit 3 sync serial, bit 2 CC one.
// - Second register: bit 7 gates the oscillator failure interrupt.
// - Second register: bits 5, 6, 1 gate comparators one, two, three.
// - Second register: bit 4 gates EEPROM write completion.
// - Second register: bit 3 gates sync serial bus collision.
// - Second register: bit 2 display driver, bit 0 CC two.
// - Group enable is bit 6 of main control; 1 enables all when global enable bit 7 is also 1.
package pie_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_ENABLE_ONE = 8'h00;
    localparam logic [7:0] OFS_ENABLE_TWO = 8'h04;
    localparam logic [7:0] OFS_MAIN_CTRL = 8'h08;
    localparam logic [7:0] OFS_FLAG_VIEW = 8'h0c;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_TIMER_ONE_OVERFLOW = 0;
    localparam int BIT_TIMER_TWO_MATCH = 1;
    localparam int BIT_CAPTURE_COMPARE_ONE = 2;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_SERIAL_TRANSMIT = 4;
    localparam int BIT_SERIAL_RECEIVE = 5;
    localparam int BIT_CONVERTER_DONE = 6;
    localparam int BIT_TIMER_ONE_GATE = 7;
    localparam int BIT_CAPTURE_COMPARE_TWO = 0;
    localparam int BIT_COMPARATOR_THREE = 1;
    localparam int BIT_DISPLAY_DRIVER = 2;
    localparam int BIT_BUS_COLLISION = 3;
    localparam int BIT_EEPROM_WRITE_DONE = 4;
    localparam int BIT_COMPARATOR_ONE = 5;
    localparam int BIT_COMPARATOR_TWO = 6;
    localparam int BIT_OSC_FAILURE = 7;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN = 6;
    localparam int EVT_REQ_RISE = 0;
    localparam int EVT_BLOCKED = 1;
    localparam int EVT_W = 2;

    // ****************************************
    // Reset values and constants
    // ****************************************
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0] MAIN_CTRL_MASK = 8'hc0;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] two;
        logic [7:0] one;
    } periph_vec_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } addr_phase_t;

    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction

endpackage

// file: rtl/periph_request_gate.sv
// Module: gates peripheral flags by enables, group and global enable
`timescale 1ns/100ps
`default_nettype none
module periph_request_gate
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sources and enables
    input wire periph_vec_t flags,
    input wire periph_vec_t enables,
    input wire logic group_en,
    input wire logic global_en,
    // Requests
    output periph_vec_t source_req,
    output logic cpu_req,
    output logic blocked
);

    wire logic both_en;
    wire logic [15:0] armed;

    assign both_en = group_en & global_en;
    // Flags keep setting upstream; only the request is gated here
    assign armed = flags & enables;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            source_req <= '0;
            cpu_req <= 1'b0;
            blocked <= 1'b0;
        end else begin
            source_req <= armed & {16{both_en}};
            cpu_req <= (|armed) & both_en;
            blocked <= (|armed) & ~both_en;
        end
    end

endmodule
`default_nettype wire

// file: rtl/event_status.sv
// Module: sticky event bits, write-one-to-clear, masked interrupt level
`timescale 1ns/100ps
`default_nettype none
module event_status
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Events and software access
    input wire logic [EVT_W-1:0] set,
    input wire logic clr_we,
    input wire logic [EVT_W-1:0] clr_data,
    input wire logic [EVT_W-1:0] mask,
    // State
    output logic [EVT_W-1:0] status,
    output logic irq
);

    wire logic [EVT_W-1:0] clr_bits;
    wire logic [EVT_W-1:0] next_status;

    assign clr_bits = clr_we ? clr_data : RST_EVT;
    // Set is ORed after the clear so a same-cycle event is never lost
    assign next_status = (status & ~clr_bits) | set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= RST_EVT;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end

endmodule
`default_nettype wire

// file: rtl/peripheral_interrupt_enables.sv
// Module: peripheral interrupt enable registers behind an AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_enables
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Peripheral flag sources
    input wire periph_vec_t flags,
    // Processor side
    output periph_vec_t source_req,
    output logic cpu_irq_req,
    output logic irq
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] peripheral_irq_enable_one;
    logic [7:0] peripheral_irq_enable_two;
    logic [7:0] main_interrupt_control;
    logic [EVT_W-1:0] evt_mask;
    addr_phase_t aphase;
    logic cpu_req_prev;
    logic blocked_prev;

    wire logic [EVT_W-1:0] evt_status;
    wire logic blocked;
    wire logic peripheral_group_enable;
    wire logic global_interrupt_enable;
    wire periph_vec_t enables;

    // ****************************************
    // Bus decode
    // ****************************************
    // Only whole-word transfers are expected; hsize is not checked
    wire logic take;
    wire logic wr_go;
    wire logic we_one;
    wire logic we_two;
    wire logic we_ctrl;
    wire logic we_clr;
    wire logic we_mask;
    wire logic [7:0] rd_addr;
    wire logic [31:0] rd_value;

    assign take = hsel & htrans[1] & hready;
    assign wr_go = aphase.valid & aphase.write;
    assign we_one = wr_go & reg_hit(aphase.addr, OFS_ENABLE_ONE);
    assign we_two = wr_go & reg_hit(aphase.addr, OFS_ENABLE_TWO);
    assign we_ctrl = wr_go & reg_hit(aphase.addr, OFS_MAIN_CTRL);
    assign we_clr = wr_go & reg_hit(aphase.addr, OFS_EVT_STATUS);
    assign we_mask = wr_go & reg_hit(aphase.addr, OFS_EVT_MASK);
    assign rd_addr = haddr[7:0];

    // Unmapped offsets read zero and ignore writes
    assign rd_value =
        reg_hit(rd_addr, OFS_ENABLE_ONE) ?
            {24'h000000, peripheral_irq_enable_one} :
        reg_hit(rd_addr, OFS_ENABLE_TWO) ?
            {24'h000000, peripheral_irq_enable_two} :
        reg_hit(rd_addr, OFS_MAIN_CTRL) ?
            {24'h000000, main_interrupt_control} :
        reg_hit(rd_addr, OFS_FLAG_VIEW) ?
            {16'h0000, flags} :
        reg_hit(rd_addr, OFS_EVT_STATUS) ?
            {30'h00000000, evt_status} :
        reg_hit(rd_addr, OFS_EVT_MASK) ?
            {30'h00000000, evt_mask} :
            32'h00000000;

    assign peripheral_group_enable =
        main_interrupt_control[BIT_GROUP_EN];
    assign global_interrupt_enable =
        main_interrupt_control[BIT_GLOBAL_EN];
    assign enables = {peripheral_irq_enable_two,
                      peripheral_irq_enable_one};

    // ****************************************
    // Bus slave
    // ****************************************
    // Zero wait states: a read is fetched during its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            aphase <= '{addr: haddr[7:0], write: hwrite, valid: take};
            if (take && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peripheral_irq_enable_one <= RST_ENABLE;
            peripheral_irq_enable_two <= RST_ENABLE;
            main_interrupt_control <= RST_MAIN_CTRL;
            evt_mask <= RST_EVT;
        end else begin
            if (we_one) begin
                peripheral_irq_enable_one <= hwdata[7:0];
            end
            if (we_two) begin
                peripheral_irq_enable_two <= hwdata[7:0];
            end
            if (we_ctrl) begin
                main_interrupt_control <= hwdata[7:0] & MAIN_CTRL_MASK;
            end
            if (we_mask) begin
                evt_mask <= hwdata[EVT_W-1:0];
            end
        end
    end

    // ****************************************
    // Request gating
    // ****************************************
    periph_request_gate u_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .flags(flags),
        .enables(enables),
        .group_en(peripheral_group_enable),
        .global_en(global_interrupt_enable),
        .source_req(source_req),
        .cpu_req(cpu_irq_req),
        .blocked(blocked)
    );

    // ****************************************
    // Event status and interrupt
    // ****************************************
    wire logic [EVT_W-1:0] evt_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_req_prev <= 1'b0;
            blocked_prev <= 1'b0;
        end else begin
            cpu_req_prev <= cpu_irq_req;
            blocked_prev <= blocked;
        end
    end

    // A blocked event flags a source that is armed but held back
    assign evt_set[EVT_REQ_RISE] = cpu_irq_req & ~cpu_req_prev;
    assign evt_set[EVT_BLOCKED] = blocked & ~blocked_prev;

    event_status u_status (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(evt_set),
        .clr_we(we_clr),
        .clr_data(hwdata[EVT_W-1:0]),
        .mask(evt_mask),
        .status(evt_status),
        .irq(irq)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire logic both_en;
    assign both_en = peripheral_group_enable & global_interrupt_enable;

    property p_group_blocks;
        !peripheral_group_enable |=> !cpu_irq_req && source_req == '0;
    endproperty
    a_group_blocks: assert property (p_group_blocks)
        else $error("request left with group enable clear");

    property p_reset_clear;
        $rose(hresetn) |->
            peripheral_irq_enable_one == RST_ENABLE &&
            peripheral_irq_enable_two == RST_ENABLE;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("enable register not clear after reset");

    property p_write_read_back;
        logic [7:0] v;
        (we_two, v = hwdata[7:0]) ##1 take && !hwrite &&
            reg_hit(haddr[7:0], OFS_ENABLE_TWO) |=>
            hrdata == {24'h000000, v};
    endproperty
    a_write_read_back: assert property (p_write_read_back)
        else $error("second enable register read back wrong");

    property p_first_bitwise;
        1'b1 |=> source_req.one == $past(flags.one &
            peripheral_irq_enable_one & {8{both_en}});
    endproperty
    a_first_bitwise: assert property (p_first_bitwise)
        else $error("first register gating wrong");

    property p_timer_one_bits;
        flags.one[BIT_TIMER_ONE_GATE] &&
            peripheral_irq_enable_one[BIT_TIMER_ONE_GATE] && both_en &&
            !peripheral_irq_enable_one[BIT_TIMER_ONE_OVERFLOW] |=>
            source_req.one[BIT_TIMER_ONE_GATE] &&
            !source_req.one[BIT_TIMER_ONE_OVERFLOW];
    endproperty
    a_timer_one_bits: assert property (p_timer_one_bits)
        else $error("timer one enable bits misplaced");

    property p_second_bitwise;
        1'b1 |=> source_req.two == $past(flags.two &
            peripheral_irq_enable_two & {8{both_en}});
    endproperty
    a_second_bitwise: assert property (p_second_bitwise)
        else $error("second register gating wrong");

    property p_group_bit;
        we_ctrl |=> peripheral_group_enable == $past(hwdata[BIT_GROUP_EN]);
    endproperty
    a_group_bit: assert property (p_group_bit)
        else $error("group enable not taken from its bit");

    property p_cpu_request;
        1'b1 |=> cpu_irq_req ==
            $past((|(flags & enables)) & both_en);
    endproperty
    a_cpu_request: assert property (p_cpu_request)
        else $error("processor request does not match its causes");

    property p_set_wins;
        we_clr && evt_set[EVT_REQ_RISE] |=> evt_status[EVT_REQ_RISE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against a clear");

    // The level is registered, so a mask write shows one cycle later
    property p_irq_level;
        1'b1 |=> irq == (|(evt_status & $past(evt_mask)));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level does not follow status and mask");

    property p_zero_wait;
        take |=> hreadyout && hresp == HRESP_OKAY;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("slave stalled or answered an error");

    c_request: cover property (!cpu_irq_req ##1 cpu_irq_req);
    c_blocked: cover property (blocked && !peripheral_group_enable);
    c_clear_race: cover property (we_clr && |evt_set);
    c_irq: cover property ($rose(irq));

endmodule
`default_nettype wire

// file: sim/periph_flag_source.sv
// Partner model: peripheral flag sources feeding the enable block
`timescale 1ns/100ps
`default_nettype none
module periph_flag_source
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control from the bench
    input wire logic [15:0] pattern,
    input wire logic slow,
    // Flags toward the block
    output periph_vec_t flags
);
    // ****************************************
    // Flag levels
    // ****************************************
    logic [15:0] stage;

    // Slow sources raise their flags a cycle late, like a peripheral
    // running from a divided clock; the block must not depend on timing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage <= 16'h0;
            flags <= '0;
        end else begin
            stage <= pattern;
            flags <= slow ? stage : pattern;
        end
    end
endmodule
`default_nettype wire

// file: sim/peripheral_interrupt_enables_tb_top.sv
// Testbench: self-checking bench for the peripheral interrupt enables
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_enables_tb_top
    import pie_pkg::*;
();
    // ****************************************
    // Signals
    // ****************************************
    logic hclk, hresetn, hsel, hwrite, hready, slow;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, cpu_irq_req, irq;
    logic [31:0] hrdata;
    periph_vec_t flags, source_req;
    logic [15:0] pattern, e, p;
    logic [7:0] c;
    int seed, fail_count, check_count, cycles, i;

    assign hready = hreadyout;

    peripheral_interrupt_enables uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .flags(flags), .source_req(source_req),
        .cpu_irq_req(cpu_irq_req), .irq(irq)
    );

    periph_flag_source src (
        .hclk(hclk), .hresetn(hresetn), .pattern(pattern), .slow(slow),
        .flags(flags)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs some 1200 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    function automatic logic [15:0] exp_req(input logic [15:0] f,
            input logic [15:0] en, input logic [7:0] ct);
        return (ct[BIT_GLOBAL_EN] && ct[BIT_GROUP_EN]) ? (f & en) : 16'h0;
    endfunction

    // ****************************************
    // Bus master
    // ****************************************
    // Called just after a rising edge; returns just after one
    task automatic bus_op(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        // Only the bench ceiling ends a wait that never sees ready
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_op(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        bus_op(1'b0, a, 32'h0, q);
        check(name, q, exp);
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
    endtask

    // Requests lag flags by one cycle, flags lag the pattern up to two
    task automatic req_chk(input logic [15:0] exp);
        repeat (4) @(posedge hclk);
        #1;
        check("source_req", {16'h0, source_req}, {16'h0, exp});
        check("cpu_irq_req", {31'h0, cpu_irq_req}, {31'h0, |exp});
        @(posedge hclk);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge hclk);
        #1;
        check("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge hclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 98939;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pattern = 16'h0;
        slow = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("enable_one reset", OFS_ENABLE_ONE, 32'h0);
        rd_chk("enable_two reset", OFS_ENABLE_TWO, 32'h0);
        check("req reset", {16'h0, source_req}, 32'h0);
        // One enable at a time, then all but one, with every flag up
        wr(OFS_MAIN_CTRL, 32'hc0);
        pattern <= 16'hffff;
        for (i = 0; i < 16; i++) begin
            e = 16'h1 << i;
            wr(OFS_ENABLE_ONE, {24'h0, e[7:0]});
            wr(OFS_ENABLE_TWO, {24'h0, e[15:8]});
            req_chk(e);
            wr(OFS_ENABLE_ONE, {24'h0, ~e[7:0]});
            wr(OFS_ENABLE_TWO, {24'h0, ~e[15:8]});
            req_chk(~e);
        end
        // Group or global enable clear holds everything back
        wr(OFS_ENABLE_ONE, 32'hff);
        wr(OFS_ENABLE_TWO, 32'hff);
        wr(OFS_MAIN_CTRL, 32'h80);
        req_chk(16'h0);
        wr(OFS_MAIN_CTRL, 32'h40);
        req_chk(16'h0);
        wr(OFS_MAIN_CTRL, 32'hc0);
        pattern <= 16'h0;
        req_chk(16'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        // Random enables, control and flags with readback
        for (i = 0; i < 40; i++) begin
            e = 16'($random(seed));
            c = 8'($random(seed));
            p = 16'($random(seed));
            if (i % 4 == 0)
                c[7:6] = 2'b11;
            slow <= p[3] ^ e[5];
            wr(OFS_ENABLE_ONE, {24'hffffff, e[7:0]});
            wr(OFS_ENABLE_TWO, {24'hffffff, e[15:8]});
            // Read straight after the write's data phase
            rd_chk("enable_two back", OFS_ENABLE_TWO, {24'h0, e[15:8]});
            wr(OFS_MAIN_CTRL, {24'h0, c});
            pattern <= p;
            rd_chk("enable_one", OFS_ENABLE_ONE, {24'h0, e[7:0]});
            rd_chk("enable_two", OFS_ENABLE_TWO, {24'h0, e[15:8]});
            rd_chk("main_ctrl", OFS_MAIN_CTRL, {24'h0, c & 8'hc0});
            req_chk(exp_req(p, e, c));
        end
        // Event status, mask and write-one-to-clear
        pattern <= 16'h0;
        slow <= 1'b0;
        wr(OFS_MAIN_CTRL, 32'hc0);
        wr(OFS_ENABLE_ONE, 32'h1);
        wr(OFS_ENABLE_TWO, 32'h0);
        wr(OFS_EVT_STATUS, 32'h3);
        wr(OFS_EVT_MASK, 32'h3);
        irq_chk(1'b0);
        pattern <= 16'h1;
        req_chk(16'h1);
        rd_chk("flag view", OFS_FLAG_VIEW, 32'h1);
        irq_chk(1'b1);
        rd_chk("status rise", OFS_EVT_STATUS, 32'h1 << EVT_REQ_RISE);
        wr(OFS_EVT_STATUS, 32'h1);
        irq_chk(1'b0);
        wr(OFS_EVT_MASK, 32'h0);
        wr(OFS_MAIN_CTRL, 32'h80);
        irq_chk(1'b0);
        rd_chk("status blocked", OFS_EVT_STATUS, 32'h1 << EVT_BLOCKED);
        wr(OFS_EVT_MASK, 32'h2);
        irq_chk(1'b1);
        wr(OFS_EVT_STATUS, 32'h2);
        irq_chk(1'b0);
        // Reset in mid-run clears the enables again
        wr(OFS_ENABLE_ONE, 32'ha5);
        wr(OFS_ENABLE_TWO, 32'h5a);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("enable_one rerun", OFS_ENABLE_ONE, 32'h0);
        rd_chk("enable_two rerun", OFS_ENABLE_TWO, 32'h0);
        rd_chk("main_ctrl rerun", OFS_MAIN_CTRL, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
